// >>> photon_gate.sv
// Purpose: two-channel gated edge counter with trigger-qualified start
// Assumes: detector, gate and trigger inputs synchronous to i_sys_clk
// Notes: registers over apb, one wait state on every transfer
`timescale 1ns/10ps
module photon_gate
   import photon_gate_pkg::*;
#(
   parameter int N_CH = 2, // count channels
   parameter int CNT_W = 32 // counter width
) (
   input wire logic i_sys_clk, // 50 MHz
   input wire logic i_resetn, // synchronous, active low
   input wire logic [N_CH-1:0] i_count, // detector pulses
   input wire logic [N_CH-1:0] i_gate, // gate levels
   input wire logic i_trigger, // trigger level
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_busy, // armed or recording active
   output logic o_armed, // waiting for trigger
   output logic o_point_done // one-cycle pulse per interval
);
   ////////////////////////////////////////////////////////////////
   // elaboration checks
   if (N_CH != 2) begin : g_bad_ch
      $error("photon_gate serves exactly two channels");
   end
   if (CNT_W != 32) begin : g_bad_w
      $error("photon_gate counter width must be 32");
   end
   ////////////////////////////////////////////////////////////////
   // declarations
   logic [1:0] edge_q; // count edge select
   logic [1:0] gpol_q; // gate polarity
   trig_t trig_q; // trigger condition
   logic step_q; // per-point step action
   logic accu_q; // accumulate
   logic [31:0] interval_q; // cycles per point
   logic [15:0] points_q; // points per curve
   seq_t state_q; // sequencer state
   logic [31:0] timer_q; // interval timer
   logic [15:0] point_q; // point index
   logic [N_CH-1:0] cnt_prev_q; // previous count level
   logic trig_prev_q; // previous trigger level
   logic [CNT_W-1:0] cnt_q [N_CH]; // running counts
   logic [CNT_W-1:0] res_q [N_CH]; // latched results
   logic [N_CH-1:0] cnt_ev; // active count edge seen
   logic [N_CH-1:0] gate_on; // gate at active level
   logic trig_ev; // qualifying trigger edge
   logic wr_acc; // write access cycle
   logic rd_acc; // read access cycle
   logic start_cmd; // software start
   logic stop_cmd; // software stop
   logic int_end; // last cycle of interval
   logic last_pt; // ending point is last of curve
   logic [31:0] rd_d; // read mux
   logic map_d; // address is mapped
   ////////////////////////////////////////////////////////////////
   // apb access decode, taken in the cycle before pready rises
   // acting only while pready is still low keeps a master that holds
   // penable through the answer cycle from writing twice
   assign wr_acc = i_psel & i_penable & ~o_pready & i_pwrite;
   assign rd_acc = i_psel & i_penable & ~o_pready & ~i_pwrite;
   assign start_cmd = wr_acc & (i_paddr == OFS_CMD) & i_pwdata[CMD_START];
   assign stop_cmd = wr_acc & (i_paddr == OFS_CMD) & i_pwdata[CMD_STOP];
   ////////////////////////////////////////////////////////////////
   // edge detection and gating per channel
   // inputs are synchronous, so one history flop per pin is enough and an
   // edge is a level change against the previous cycle's sample
   for (genvar c = 0; c < N_CH; c++) begin : g_ch
      // rising when select set, falling otherwise
      assign cnt_ev[c] = edge_q[c] ? (i_count[c] & ~cnt_prev_q[c]) :
                         (~i_count[c] & cnt_prev_q[c]);
      // gate level compared with its own polarity only
      assign gate_on[c] = ~(i_gate[c] ^ gpol_q[c]);
   end
   ////////////////////////////////////////////////////////////////
   // trigger edge qualifier
   // code 3 falls to the default branch and never fires, so a start with
   // it stays armed until a stop
   always_comb begin
      case (trig_q)
         TRIG_RISE: trig_ev = i_trigger & ~trig_prev_q;
         TRIG_FALL: trig_ev = ~i_trigger & trig_prev_q;
         default: trig_ev = 1'b0;
      endcase
   end
   // interval end: the timer is in the last cycle of the point
   assign int_end = (state_q == S_RUN) & (timer_q >= interval_q - 32'h1);
   // ending point is the last of the curve or sweep
   assign last_pt = (point_q >= points_q - 16'h1);
   ////////////////////////////////////////////////////////////////
   // input history
   // history resets low, the idle level of the far side, so no false edge
   // is seen right after reset
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         cnt_prev_q <= '0;
         trig_prev_q <= 1'b0;
      end else begin
         cnt_prev_q <= i_count;
         trig_prev_q <= i_trigger;
      end
   end
   ////////////////////////////////////////////////////////////////
   // configuration registers
   // writes land in the access cycle only; other offsets change nothing
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         edge_q <= EDGE_RESET;
         gpol_q <= GPOL_RESET;
         trig_q <= TRIG_NONE;
         step_q <= 1'b0;
         accu_q <= 1'b0;
         interval_q <= INTERVAL_RESET;
         points_q <= POINTS_RESET;
      end else if (wr_acc) begin
         case (i_paddr)
            OFS_CTRL: begin
               edge_q <= i_pwdata[CTL_EDGE+:2];
               gpol_q <= i_pwdata[CTL_GPOL+:2];
               trig_q <= trig_t'(i_pwdata[CTL_TRIG+:2]);
               step_q <= i_pwdata[CTL_STEP];
               accu_q <= i_pwdata[CTL_ACCU];
            end
            // zero interval would never end, hold at one
            OFS_INTERVAL: interval_q <= (i_pwdata == 32'h0) ? 32'h1 : i_pwdata;
            OFS_POINTS: points_q <= (i_pwdata[15:0] == 16'h0) ? 16'h1 : i_pwdata[15:0];
            default: ;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////
   // recording sequencer
   // stop is tested first so that it wins over a start in the same word;
   // a start while busy falls through the case and is dropped
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         state_q <= S_IDLE;
         point_q <= 16'h0;
      end else if (stop_cmd) begin
         state_q <= S_IDLE;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (start_cmd) begin
                  point_q <= 16'h0;
                  // no condition starts at once
                  state_q <= (trig_q == TRIG_NONE) ? S_RUN : S_ARMED;
               end
            end
            S_ARMED: begin
               if (trig_ev || trig_q == TRIG_NONE) begin
                  state_q <= S_RUN;
               end
            end
            S_RUN: begin
               // trigger edges ignored while running
               if (int_end) begin
                  if (!last_pt) begin
                     point_q <= point_q + 16'h1;
                     // each point waits for its own edge
                     state_q <= (step_q && trig_q != TRIG_NONE) ? S_ARMED : S_RUN;
                  end else if (accu_q) begin
                     point_q <= 16'h0;
                     // next sweep, one trigger per sweep
                     state_q <= (trig_q == TRIG_NONE) ? S_RUN : S_ARMED;
                  end else begin
                     state_q <= S_IDLE;
                  end
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////
   // interval timer
   // zero based; runs only while recording and restarts at each interval end
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         timer_q <= 32'h0;
      end else if (state_q != S_RUN || int_end) begin
         timer_q <= 32'h0;
      end else begin
         timer_q <= timer_q + 32'h1;
      end
   end
   ////////////////////////////////////////////////////////////////
   // gated counters, edge sampled against gate level
   // counters wrap at their width; even the longest interval at full rate stays below it
   for (genvar c = 0; c < N_CH; c++) begin : g_cnt
      logic inc; // qualified count this cycle
      // gate inactive blocks edge; an unused gate is held active outside
      assign inc = (state_q == S_RUN) & cnt_ev[c] & gate_on[c];
      always_ff @(posedge i_sys_clk) begin
         if (!i_resetn) begin
            cnt_q[c] <= '0;
            res_q[c] <= '0;
         end else if (int_end) begin
            // edge on the last cycle still lands in the result
            res_q[c] <= cnt_q[c] + {{(CNT_W-1){1'b0}}, inc};
            cnt_q[c] <= '0;
         end else if (state_q != S_RUN) begin
            cnt_q[c] <= '0;
         end else if (inc) begin
            cnt_q[c] <= cnt_q[c] + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   // read mux
   // unmapped offsets raise the error flag and read as zero
   always_comb begin
      rd_d = 32'h0;
      map_d = 1'b1;
      case (i_paddr)
         OFS_CTRL: rd_d = {24'h0, accu_q, step_q, trig_q, gpol_q, edge_q};
         OFS_CMD: rd_d = 32'h0;
         OFS_INTERVAL: rd_d = interval_q;
         OFS_POINTS: rd_d = {16'h0, points_q};
         OFS_STATUS: rd_d = {point_q, 12'h0, gpol_q,
                             state_q == S_ARMED, state_q != S_IDLE};
         OFS_COUNT0: rd_d = res_q[0];
         OFS_COUNT1: rd_d = res_q[1];
         OFS_THRESH: rd_d = THRESH_ROM[0];
         OFS_THRESH + 8'h04: rd_d = THRESH_ROM[1];
         OFS_THRESH + 8'h08: rd_d = THRESH_ROM[2];
         OFS_THRESH + 8'h0C: rd_d = THRESH_ROM[3];
         default: map_d = 1'b0;
      endcase
   end
   ////////////////////////////////////////////////////////////////
   // apb answer, one wait state
   // pready is a one-cycle pulse; a held penable raises it again every second cycle
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h0;
      end else begin
         o_pready <= i_psel & i_penable & ~o_pready;
         o_pslverr <= i_psel & i_penable & ~o_pready & ~map_d;
         o_prdata <= (rd_acc && map_d) ? rd_d : 32'h0;
      end
   end
   ////////////////////////////////////////////////////////////////
   // status outputs
   // one cycle behind the sequencer so every top output leaves a flop
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_busy <= 1'b0;
         o_armed <= 1'b0;
         o_point_done <= 1'b0;
      end else begin
         o_busy <= (state_q != S_IDLE);
         o_armed <= (state_q == S_ARMED);
         o_point_done <= int_end;
      end
   end
   ////////////////////////////////////////////////////////////////
   // assertions
   // all checks share the system clock and are off during reset
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);

   property p_reset_cfg;
      $rose(i_resetn) |-> edge_q == 2'h0 && gpol_q == 2'h3;
   endproperty
   a_edge_reset_fall: assert property (p_reset_cfg)
      else $error("edge or gate polarity reset value wrong");
   a_gate_reset_high: assert property ($rose(i_resetn) |-> gpol_q[0] && gpol_q[1])
      else $error("gate not active high after reset");
   a_count_on_edge: assert property (state_q == S_RUN && !int_end && cnt_ev[0] &&
      gate_on[0] |=> cnt_q[0] == $past(cnt_q[0]) + 32'h1)
      else $error("qualified edge not counted on ch0");
   a_gate_blocks_count: assert property (state_q == S_RUN && !int_end &&
      !gate_on[1] |=> cnt_q[1] == $past(cnt_q[1]))
      else $error("ch1 counted with gate inactive");
   a_edge_select_fall: assert property (state_q == S_RUN && !int_end && !edge_q[0] &&
      $rose(i_count[0]) |=> cnt_q[0] == $past(cnt_q[0]))
      else $error("rising edge counted in falling mode");
   a_start_software: assert property (state_q == S_IDLE && start_cmd && !stop_cmd &&
      trig_q == TRIG_NONE |=> state_q == S_RUN ##1 o_busy)
      else $error("software start did not run");
   a_start_armed: assert property (state_q == S_IDLE && start_cmd && !stop_cmd &&
      trig_q != TRIG_NONE |=> state_q == S_ARMED ##1 o_armed)
      else $error("edge condition did not arm");
   a_trig_starts_run: assert property (state_q == S_ARMED && trig_ev &&
      !stop_cmd |=> state_q == S_RUN)
      else $error("trigger edge did not start recording");
   a_curve_continues: assert property (int_end && !last_pt && !step_q &&
      !stop_cmd |=> state_q == S_RUN && timer_q == 32'h0)
      else $error("curve stopped between points");
   a_point_rearms: assert property (int_end && !last_pt && step_q &&
      trig_q != TRIG_NONE && !stop_cmd |=> state_q == S_ARMED)
      else $error("point did not wait for trigger");
   a_trig_ignored: assert property (state_q == S_RUN && !int_end && !stop_cmd &&
      trig_ev |=> state_q == S_RUN && timer_q == $past(timer_q) + 32'h1)
      else $error("trigger disturbed running interval");
   a_gate_readback: assert property (rd_acc && i_paddr == OFS_STATUS |=>
      o_prdata[ST_GPOL+:2] == $past(gpol_q) && o_pready)
      else $error("gate polarity readback wrong");
   a_apb_one_wait: assert property ($rose(i_psel & i_penable) |-> !o_pready ##1 o_pready)
      else $error("apb answer not after one wait state");

   // a result holds every qualified edge of its interval, the last cycle too
   a_result_latch: assert property (int_end |=> res_q[1] == $past(cnt_q[1]) +
      32'($past(g_cnt[1].inc)))
      else $error("interval result lost an edge on ch1");
   // outside recording the running count is held clear
   a_idle_clear: assert property (state_q != S_RUN |=> cnt_q[0] == 32'h0)
      else $error("ch0 counted outside recording");
   // low gate polarity blocks edges while the gate sits high
   a_gate_low_blocks: assert property (state_q == S_RUN && !int_end && !gpol_q[0] &&
      i_gate[0] |=> cnt_q[0] == $past(cnt_q[0]))
      else $error("ch0 counted with low gate polarity and gate high");
   // rising selection on ch1 ignores falling edges
   a_edge_select_rise: assert property (state_q == S_RUN && !int_end && edge_q[1] &&
      $fell(i_count[1]) |=> cnt_q[1] == $past(cnt_q[1]))
      else $error("falling edge counted on ch1 in rising mode");
   // an armed sequencer waits for its own edge only
   a_armed_holds: assert property (state_q == S_ARMED && !trig_ev &&
      trig_q != TRIG_NONE && !stop_cmd |=> state_q == S_ARMED)
      else $error("armed sequencer left without trigger edge");
   // stop returns to idle from any state
   a_stop_idles: assert property (stop_cmd |=> state_q == S_IDLE)
      else $error("stop command did not return to idle");
   // every interval end gives one done pulse
   a_done_pulse: assert property (int_end |=> o_point_done)
      else $error("interval end without done pulse");
   // unmapped offsets answer with an error and zero data
   a_unmapped_err: assert property (i_psel && i_penable && !o_pready && !map_d |=>
      o_pslverr && o_prdata == 32'h0)
      else $error("unmapped access not refused");

   c_software_run: cover property (state_q == S_IDLE ##1 state_q == S_RUN);
   c_trig_run: cover property (state_q == S_ARMED ##1 state_q == S_RUN);
   c_point_rearm: cover property (int_end && step_q ##1 state_q == S_ARMED);
   c_gated_count: cover property (state_q == S_RUN && cnt_ev[1] && gate_on[1]);
   c_sweep_repeat: cover property (int_end && last_pt && accu_q ##1 state_q == S_RUN);
endmodule

// >>> photon_gate_pkg.sv
// Purpose: constants for the gated photon counter input block
// Assumes: apb register map, 32-bit data, one 50 MHz clock
// Notes: threshold constants are stand-in values
//
// Summary of operation
// - count one edge in the chosen direction
// - count edge selection resets to falling
// - edge and gate polarity set per channel
// - count only while gate holds active level
// - gate polarity selectable high or low
// - gate polarity resets to active high
// - edge inside gate counts, pulse width irrelevant
// - window set by gate width within each point interval
// - start by software, rising or falling trigger
// - without per-point step, trigger starts whole curve
// - with per-point step, each interval awaits trigger
// - host reads back gate polarity per channel
// - threshold range constants readable from storage
package photon_gate_pkg;
   ////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00; // config, rw
   localparam logic [7:0] OFS_CMD = 8'h04; // start/stop, wo
   localparam logic [7:0] OFS_INTERVAL = 8'h08; // cycles per point
   localparam logic [7:0] OFS_POINTS = 8'h0C; // points per curve
   localparam logic [7:0] OFS_STATUS = 8'h10; // state, ro
   localparam logic [7:0] OFS_COUNT0 = 8'h14; // last result ch0
   localparam logic [7:0] OFS_COUNT1 = 8'h18; // last result ch1
   localparam logic [7:0] OFS_THRESH = 8'h20; // 4 words of constants
   ////////////////////////////////////////////////////////////////
   // control, command and status field positions
   localparam int CTL_EDGE = 0; // bits 1:0, 1 = rising edge
   localparam int CTL_GPOL = 2; // bits 3:2, 1 = active high
   localparam int CTL_TRIG = 4; // bits 5:4 trigger condition
   localparam int CTL_STEP = 6; // per-point step action
   localparam int CTL_ACCU = 7; // accumulate sweeps
   localparam int CMD_START = 0;
   localparam int CMD_STOP = 1;
   localparam int ST_BUSY = 0;
   localparam int ST_ARMED = 1;
   localparam int ST_GPOL = 2; // bits 3:2 gate polarity readback
   localparam int ST_POINT = 16; // bits 31:16 point index
   ////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [1:0] EDGE_RESET = 2'h0; // falling on both
   localparam logic [1:0] GPOL_RESET = 2'h3; // active high on both
   localparam logic [31:0] INTERVAL_RESET = 32'h0000_0064;
   localparam logic [15:0] POINTS_RESET = 16'h0001;
   // threshold range constants, arbitrary stand-in values
   localparam logic [31:0] THRESH_ROM [4] = '{32'h0000_0000, 32'h0000_0000,
                                               32'h0000_0000, 32'h0000_0000};
   ////////////////////////////////////////////////////////////////
   // trigger condition and sequencer states
   typedef enum logic [1:0] {TRIG_NONE, TRIG_RISE, TRIG_FALL, TRIG_RSVD} trig_t;
   typedef enum logic [1:0] {S_IDLE, S_ARMED, S_RUN} seq_t;
endpackage

// >>> photon_src.sv
// Purpose: far-side model: detector pulses, gate source and trigger source
// Assumes: every output moves right after a rising clock edge
// Notes: pulses and gates only move while i_act is high, so no edge leaks out
`timescale 1ns/10ps
module photon_src (
   input wire logic i_sys_clk, // bench clock
   input wire logic i_act, // let pulses and gates move
   input wire logic i_free, // no gate source attached
   input wire logic [1:0] i_gpol, // configured gate polarity
   input wire logic i_trig_lvl, // wanted trigger level
   output logic [1:0] o_count, // detector pulse levels
   output logic [1:0] o_gate, // gate levels
   output logic o_trigger // trigger level
);
   integer seed = 50089; // fixed seed for repeatable runs
   logic [1:0] cnt_q = 2'h0; // pulse levels
   logic [1:0] gate_q = 2'h0; // gate source levels
   logic trig_q = 1'b0; // trigger source level
   ////////////////////////////////////////////////////////////////
   // random pulses of any width, random short gates, both per channel
   always @(posedge i_sys_clk) begin
      if (i_act) begin
         cnt_q <= 2'($random(seed));
         gate_q <= 2'($random(seed)); // gates often narrower than pulses
      end
   end
   // with no gate source the gate sits at its active level
   assign o_gate = i_free ? i_gpol : gate_q;
   assign o_count = cnt_q;
   // trigger follows the bench's wish one edge later
   always @(posedge i_sys_clk) trig_q <= i_trig_lvl;
   assign o_trigger = trig_q;
endmodule

// >>> gated_photon_counter_inputs_tb_top.sv
// Purpose: self-checking bench for the gated counter input block
// Assumes: one wait state apb slave, interval shortened to 40 cycles
// Notes: an edge counter model follows the pins and predicts each result
`timescale 1ns/10ps
module gated_photon_counter_inputs_tb_top;
   import photon_gate_pkg::*;
   logic clk, rstn, psel, pen, pwr, act, free, tlvl; // bench drives
   logic [7:0] paddr; // apb address
   logic [31:0] pwdata, prdata; // apb data
   logic pready, pslverr, busy, armed, pdone; // design outputs
   logic [1:0] cnt_w, gate_w, gpol, edg; // pins and current config
   logic trig_w; // trigger pin
   logic [1:0] pc = 2'h0; // previous count sample
   logic [31:0] cnt [2] = '{32'h0, 32'h0}; // model edge totals
   int miscompares = 0, total_checks = 0, cyc = 0; // bookkeeping
   ////////////////////////////////////////////////////////////////
   photon_gate #(.N_CH(2), .CNT_W(32)) u_dut (.i_sys_clk(clk), .i_resetn(rstn),
      .i_count(cnt_w), .i_gate(gate_w), .i_trigger(trig_w), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_busy(busy),
      .o_armed(armed), .o_point_done(pdone));
   photon_src u_src (.i_sys_clk(clk), .i_act(act), .i_free(free), .i_gpol(gpol),
      .i_trig_lvl(tlvl), .o_count(cnt_w), .o_gate(gate_w), .o_trigger(trig_w));
   always #10 clk = ~clk;
   ////////////////////////////////////////////////////////////////
   // model: count selected edges that meet the active gate level
   always @(posedge clk) begin
      pc <= cnt_w;
      for (int c = 0; c < 2; c++) begin
         if ((edg[c] ? (!pc[c] && cnt_w[c]) : (pc[c] && !cnt_w[c])) && gate_w[c] == gpol[c]) begin
            cnt[c] <= cnt[c] + 32'h1;
         end
      end
   end
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         give_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // one compare, counted
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   // read and compare the masked bits
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
                      input string what);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(what, exp & m, r & m);
   endtask
   // wait for the interval end pulse, bounded
   task automatic wait_done(input int lim);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pdone !== 1'b1 && n < lim);
      chk("point done", 32'h1, {31'h0, pdone});
   endtask
   // one counted interval with the given edge and gate set-up
   task automatic meas(input logic [1:0] e, input logic [1:0] p, input logic fr);
      logic [31:0] b0, b1;
      edg <= e;
      gpol <= p;
      free <= fr;
      wr(OFS_CTRL, {24'h0, 4'h0, p, e});
      rdc(OFS_STATUS, {28'h0, p, 2'h0}, 32'h0000_000C, "gate pol readback");
      b0 = cnt[0];
      b1 = cnt[1];
      wr(OFS_CMD, 32'h0000_0001);
      repeat (3) @(posedge clk);
      act <= 1'b1;
      repeat (25) @(posedge clk);
      act <= 1'b0;
      wait_done(60);
      rdc(OFS_COUNT0, cnt[0] - b0, 32'hFFFF_FFFF, "count ch0");
      rdc(OFS_COUNT1, cnt[1] - b1, 32'hFFFF_FFFF, "count ch1");
   endtask
   // edge-started curve of two points, wrong edge offered first
   task automatic trig_run(input logic [1:0] code, input logic stp);
      logic t0;
      t0 = (code == 2'h1);
      tlvl <= t0;
      wr(OFS_POINTS, 32'h0000_0002);
      wr(OFS_CTRL, {24'h0, 1'b0, stp, code, 4'h0C});
      wr(OFS_CMD, 32'h0000_0001);
      repeat (4) @(posedge clk);
      chk("armed after start", 32'h1, {31'h0, armed});
      tlvl <= !t0;
      repeat (6) @(posedge clk);
      chk("armed after wrong edge", 32'h1, {31'h0, armed});
      tlvl <= t0;
      repeat (6) @(posedge clk);
      tlvl <= !t0;
      repeat (3) @(posedge clk);
      tlvl <= t0;
      wait_done(60);
      if (stp) begin
         repeat (3) @(posedge clk);
         chk("re-armed per point", 32'h1, {31'h0, armed});
         tlvl <= !t0;
         repeat (4) @(posedge clk);
         tlvl <= t0;
      end
      wait_done(60);
      repeat (4) @(posedge clk);
      chk("idle after curve", 32'h0, {30'h0, busy, armed});
   endtask
   // sweeps repeat under accumulate until stop; trigger code 3 never fires
   task automatic accu_stop();
      wr(OFS_CTRL, 32'h0000_008C);
      wr(OFS_CMD, 32'h0000_0001);
      wait_done(60);
      wait_done(60);
      chk("busy while sweeping", 32'h1, {31'h0, busy});
      wr(OFS_CMD, 32'h0000_0002);
      repeat (3) @(posedge clk);
      chk("idle after stop", 32'h0, {30'h0, busy, armed});
      wr(OFS_CTRL, 32'h0000_003C);
      wr(OFS_CMD, 32'h0000_0001);
      repeat (50) @(posedge clk);
      chk("never code stays armed", 32'h1, {31'h0, armed});
      wr(OFS_CMD, 32'h0000_0002);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      {rstn, psel, pen, pwr, act, free, tlvl} = 7'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      {gpol, edg} = 4'hC;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      rdc(OFS_CTRL, 32'h0000_000C, 32'hFFFF_FFFF, "ctrl reset");
      rdc(OFS_STATUS, 32'h0000_000C, 32'h0000_000F, "status reset");
      rdc(OFS_THRESH, THRESH_ROM[0], 32'hFFFF_FFFF, "threshold word");
      begin
         logic [31:0] r;
         logic e;
         apb(1'b0, 8'h40, 32'h0, r, e);
         chk("unmapped error", 32'h1, {31'h0, e});
      end
      wr(OFS_INTERVAL, 32'h0000_0028);
      for (int i = 0; i < 4; i++) meas(2'(i), ~2'(i), i == 0);
      trig_run(2'h1, 1'b0);
      trig_run(2'h2, 1'b1);
      accu_stop();
      give_verdict();
   end
endmodule
